// [hw/luc_counter.sv]
module luc_counter
	import luc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [LUC_ADR_W-1:0] wb_adr_i,
	input wire logic [LUC_SEL_W-1:0] wb_sel_i,
	input wire logic [LUC_DAT_W-1:0] wb_dat_i,
	output logic [LUC_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic count_enable,
	input wire logic load,
	input wire logic direction_select,
	input wire logic preset_bit3,
	input wire logic preset_bit2,
	input wire logic preset_bit1,
	input wire logic preset_bit0,
	output logic state_out_bit3,
	output logic state_out_bit2,
	output logic state_out_bit1,
	output logic state_out_bit0,
	output logic hold_state
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic sw_mode;
	logic sw_enable;
	logic sw_down;
	logic [LUC_CNT_W-1:0] sw_preset;
	logic sw_load_pulse;
	logic eff_load;
	logic eff_enable;
	logic eff_down;
	logic [LUC_CNT_W-1:0] eff_preset;
	logic [LUC_CNT_W-1:0] count;
	logic [LUC_CNT_W:0] carry;
	logic bus_req;
	logic bus_wr;
	logic [LUC_DAT_W-1:0] next_dat;

	// ----------------------------------------
	// address decode helper
	// ----------------------------------------
	function automatic logic luc_hit(input logic [LUC_ADR_W-1:0] adr, input logic [LUC_ADR_W-1:0] ofs);
		luc_hit = (adr == ofs);
	endfunction : luc_hit

	// ----------------------------------------
	// control source selection
	// ----------------------------------------
	// pins drive the counter unless software mode is set
	always_comb begin
		if (sw_mode) begin
			eff_load = sw_load_pulse;
			eff_enable = sw_enable;
			eff_down = sw_down;
			eff_preset = sw_preset;
		end else begin
			eff_load = load;
			eff_enable = count_enable;
			eff_down = direction_select;
			eff_preset = {preset_bit3, preset_bit2, preset_bit1, preset_bit0};
		end
	end

	// ----------------------------------------
	// counter slices
	// ----------------------------------------
	// enable feeds the low end of the toggle chain
	assign carry[0] = eff_enable;

	generate
		for (genvar i = 0; i < LUC_CNT_W; i++) begin : g_slice
			luc_slice u_slice (
				.clk(clk),
				.load(eff_load),
				.preset(eff_preset[i]),
				.down(eff_down),
				.carry_in(carry[i]),
				.q(count[i]),
				.carry_out(carry[i+1])
			);
		end
	endgenerate

	// state pins come straight from the slice flip-flops
	assign state_out_bit3 = count[3];
	assign state_out_bit2 = count[2];
	assign state_out_bit1 = count[1];
	assign state_out_bit0 = count[0];

	// hold indicator: neither loading nor counting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_state <= 1'b0;
		end else begin
			hold_state <= ~eff_load & ~eff_enable;
		end
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	assign bus_req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where ack is seen high
	assign bus_wr = bus_req & wb_we_i & wb_ack_o;

	// ack one cycle after the request, dropped the next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		next_dat = LUC_DAT_ZERO;
		if (luc_hit(wb_adr_i, LUC_OFS_CTRL)) begin
			next_dat[LUC_CTRL_SW_MODE] = sw_mode;
			next_dat[LUC_CTRL_ENABLE] = sw_enable;
			next_dat[LUC_CTRL_DOWN] = sw_down;
			next_dat[LUC_CTRL_PRESET_HI:LUC_CTRL_PRESET_LO] = sw_preset;
		end else if (luc_hit(wb_adr_i, LUC_OFS_STATUS)) begin
			next_dat[LUC_STAT_COUNT_HI:LUC_STAT_COUNT_LO] = count;
			next_dat[LUC_STAT_HOLD] = hold_state;
		end
	end

	// read data registered with the ack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= LUC_DAT_ZERO;
		end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
			wb_dat_o <= next_dat;
		end
	end

	// control register, byte lane 0 only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_mode <= LUC_RST_SW_MODE;
			sw_enable <= LUC_RST_ENABLE;
			sw_down <= LUC_RST_DOWN;
			sw_preset <= LUC_RST_PRESET;
		end else if (bus_wr & wb_sel_i[0] & luc_hit(wb_adr_i, LUC_OFS_CTRL)) begin
			sw_mode <= wb_dat_i[LUC_CTRL_SW_MODE];
			sw_enable <= wb_dat_i[LUC_CTRL_ENABLE];
			sw_down <= wb_dat_i[LUC_CTRL_DOWN];
			sw_preset <= wb_dat_i[LUC_CTRL_PRESET_HI:LUC_CTRL_PRESET_LO];
		end
	end

	// load strobe: one clock of load, as a pulse on the switch would give
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_load_pulse <= 1'b0;
		end else begin
			sw_load_pulse <= bus_wr & wb_sel_i[0] & luc_hit(wb_adr_i, LUC_OFS_LOAD)
				& wb_dat_i[LUC_LOAD_STROBE];
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence load_cycle_s;
		eff_load;
	endsequence

	sequence up_step_s;
		!eff_load && eff_enable && !eff_down;
	endsequence

	sequence down_step_s;
		!eff_load && eff_enable && eff_down;
	endsequence

	sequence sw_load_write_s;
		bus_wr && luc_hit(wb_adr_i, LUC_OFS_LOAD) && wb_sel_i[0] && wb_dat_i[LUC_LOAD_STROBE];
	endsequence

	load_takes_preset_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		load_cycle_s |=> count == $past(eff_preset))
		else $error("count did not take the preset on load");

	hold_keeps_state_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		rst_n && !eff_load && !eff_enable |=> count == $past(count) && hold_state)
		else $error("count changed while holding");

	step_up_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		up_step_s |=> count == 4'($past(count) + LUC_ONE))
		else $error("up step wrong");

	step_down_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		down_step_s |=> count == 4'($past(count) - LUC_ONE))
		else $error("down step wrong");

	wrap_up_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		up_step_s ##0 (count == LUC_ONES) |=> count == LUC_ZERO)
		else $error("no wrap to zero when counting up");

	wrap_down_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		down_step_s ##0 (count == LUC_ZERO) |=> count == LUC_ONES)
		else $error("no wrap to ones when counting down");

	edge_only_change_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(count != $past(count)) |-> $past(eff_load || eff_enable))
		else $error("count changed without load or enable");

	sw_clear_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		sw_mode && sw_preset == LUC_ZERO ##0 sw_load_write_s |=> sw_load_pulse ##1 count == LUC_ZERO)
		else $error("software load of zero did not clear the count");

	status_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		bus_req && !wb_we_i && !wb_ack_o && luc_hit(wb_adr_i, LUC_OFS_STATUS)
		|=> wb_ack_o && wb_dat_o[LUC_STAT_COUNT_HI:LUC_STAT_COUNT_LO] == $past(count))
		else $error("status read does not show the count");

	state_pins_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		eff_load |=> {state_out_bit3, state_out_bit2, state_out_bit1, state_out_bit0} == $past(eff_preset))
		else $error("state pins do not show the loaded value msb first");

	ack_single_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// ----------------------------------------
	// source, chain and bus assertions
	// ----------------------------------------
	sequence req_new_s;
		bus_req && !wb_ack_o;
	endsequence

	load_over_enable_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		eff_load && eff_enable |=> count == $past(eff_preset))
		else $error("counting overrode a load");

	hold_flag_clear_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		eff_load || eff_enable |=> !hold_state)
		else $error("hold flag set while loading or counting");

	pins_ignored_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		sw_mode && !sw_load_pulse && !sw_enable |=> count == $past(count))
		else $error("pins moved the count in software mode");

	chain_idle_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!eff_enable |-> carry == '0)
		else $error("toggle chain active without enable");

	carry_up_out_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		up_step_s ##0 (count == LUC_ONES) |-> carry[LUC_CNT_W])
		else $error("no carry out of the top slice counting up");

	carry_down_out_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		down_step_s ##0 (count == LUC_ZERO) |-> carry[LUC_CNT_W])
		else $error("no borrow out of the top slice counting down");

	ack_follows_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		req_new_s |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");

	unmapped_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		req_new_s ##0 (!wb_we_i && !luc_hit(wb_adr_i, LUC_OFS_CTRL) && !luc_hit(wb_adr_i, LUC_OFS_STATUS))
		|=> wb_dat_o == LUC_DAT_ZERO)
		else $error("unmapped read returned data");

	sel_gate_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		bus_wr && !wb_sel_i[0] |=> $stable({sw_mode, sw_enable, sw_down, sw_preset}))
		else $error("write without byte lane 0 changed control");

	load_pulse_once_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		sw_load_pulse |=> !sw_load_pulse)
		else $error("software load pulse longer than one cycle");
endmodule : luc_counter

// [hw/luc_pkg.sv]
package luc_pkg;
	// ----------------------------------------
	// counter geometry
	// ----------------------------------------
	localparam int LUC_CNT_W = 4;
	localparam int LUC_ADR_W = 8;
	localparam int LUC_DAT_W = 32;
	localparam int LUC_SEL_W = 4;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] LUC_OFS_CTRL = 8'h00;
	localparam logic [7:0] LUC_OFS_LOAD = 8'h04;
	localparam logic [7:0] LUC_OFS_STATUS = 8'h08;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int LUC_CTRL_SW_MODE = 0;
	localparam int LUC_CTRL_ENABLE = 1;
	localparam int LUC_CTRL_DOWN = 2;
	localparam int LUC_CTRL_PRESET_LO = 4;
	localparam int LUC_CTRL_PRESET_HI = 7;

	// ----------------------------------------
	// load and status register fields
	// ----------------------------------------
	localparam int LUC_LOAD_STROBE = 0;
	localparam int LUC_STAT_COUNT_LO = 0;
	localparam int LUC_STAT_COUNT_HI = 3;
	localparam int LUC_STAT_HOLD = 4;

	// ----------------------------------------
	// values after reset, count constants
	// ----------------------------------------
	localparam logic LUC_RST_SW_MODE = 1'b0;
	localparam logic LUC_RST_ENABLE = 1'b0;
	localparam logic LUC_RST_DOWN = 1'b0;
	localparam logic [3:0] LUC_RST_PRESET = 4'h0;
	localparam logic [3:0] LUC_ZERO = 4'h0;
	localparam logic [3:0] LUC_ONES = 4'hF;
	localparam logic [3:0] LUC_ONE = 4'h1;
	localparam logic [31:0] LUC_DAT_ZERO = 32'h0000_0000;
endpackage : luc_pkg

// [hw/luc_slice.sv]
// ----------------------------------------
// one bit of the counter: flip-flop plus count logic
// ----------------------------------------
module luc_slice
	import luc_pkg::*;
(
	input wire logic clk,
	input wire logic load,
	input wire logic preset,
	input wire logic down,
	input wire logic carry_in,
	output logic q,
	output logic carry_out
);
	logic next_q;

	// next state settles while the clock is low
	always_comb begin
		if (load) begin
			next_q = preset;
		end else begin
			next_q = q ^ carry_in;
		end
	end

	// ripple: up toggles above ones, down toggles above zeros
	assign carry_out = carry_in & (down ? ~q : q);

	// no reset: state powers up arbitrary
	always_ff @(posedge clk) begin
		q <= next_q;
	end
endmodule : luc_slice

// [test/luc_ctrl_model.sv]
// ----------------------------------------
// switch bank driving the counter pins
// ----------------------------------------
module luc_ctrl_model (
	output logic count_enable,
	output logic load,
	output logic direction_select,
	output logic preset_bit3,
	output logic preset_bit2,
	output logic preset_bit1,
	output logic preset_bit0
);
	timeunit 1ns;
	timeprecision 1ns;

	// all controls change together, ahead of the sampling edge
	task automatic drive(input logic l, input logic e, input logic d, input logic [3:0] p);
		load <= l;
		count_enable <= e;
		direction_select <= d;
		{preset_bit3, preset_bit2, preset_bit1, preset_bit0} <= p;
	endtask : drive

	// clear the arbitrary power-up count: load zero until the first scenario
	initial begin
		drive(1'b1, 1'b0, 1'b0, 4'h0);
	end
endmodule : luc_ctrl_model

// [test/luc_counter_tb.sv]
module luc_counter_tb
	import luc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [LUC_ADR_W-1:0] adr = '0;
	logic [LUC_SEL_W-1:0] sel = '0;
	logic [LUC_DAT_W-1:0] dat_i = '0;
	logic [LUC_DAT_W-1:0] dat_o;
	logic [31:0] r;
	logic ack, en, ld, dir, p3, p2, p1, p0, s3, s2, s1, s0, hold;
	int bad_count = 0;
	int cmp_count = 0;

	// ----------------------------------------
	// clock, parts
	// ----------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end

	luc_ctrl_model i_ctl (.count_enable(en), .load(ld), .direction_select(dir),
		.preset_bit3(p3), .preset_bit2(p2), .preset_bit1(p1), .preset_bit0(p0));

	luc_counter i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.count_enable(en), .load(ld), .direction_select(dir), .preset_bit3(p3), .preset_bit2(p2),
		.preset_bit1(p1), .preset_bit0(p0), .state_out_bit3(s3), .state_out_bit2(s2),
		.state_out_bit1(s1), .state_out_bit0(s0), .hold_state(hold));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_i <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) chk("ack", 32'(ack), 32'h0000_0001);
	endtask : wb

	// apply pins for n edges, then idle, then judge
	task automatic step(input logic l, input logic e, input logic d, input logic [3:0] p, input int n,
		input logic [3:0] exp);
		@(posedge clk);
		i_ctl.drive(l, e, d, p);
		repeat (n) @(posedge clk);
		i_ctl.drive(1'b0, 1'b0, d, p);
		@(negedge clk);
		chk("state", {s3, s2, s1, s0}, exp);
		chk("hold", hold, !(l | e));
	endtask : step

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_load();
		step(1'b1, 1'b1, 1'b0, 4'h0, 1, 4'h0);
		step(1'b1, 1'b0, 1'b1, 4'hA, 1, 4'hA);
		step(1'b0, 1'b0, 1'b1, 4'h3, 3, 4'hA);
	endtask : t_load

	task automatic t_count();
		step(1'b1, 1'b0, 1'b0, 4'hE, 1, 4'hE);
		step(1'b0, 1'b1, 1'b0, 4'h0, 1, 4'hF);
		step(1'b0, 1'b1, 1'b0, 4'h0, 1, 4'h0);
		step(1'b0, 1'b1, 1'b0, 4'h0, 5, 4'h5);
		step(1'b0, 1'b1, 1'b1, 4'h0, 1, 4'h4);
		step(1'b1, 1'b0, 1'b1, 4'h0, 1, 4'h0);
		step(1'b0, 1'b1, 1'b1, 4'h0, 1, 4'hF);
		step(1'b0, 1'b1, 1'b1, 4'h0, 3, 4'hC);
	endtask : t_count

	// software mode, byte lane gating, unmapped read
	task automatic t_regs();
		wb(1'b0, LUC_OFS_CTRL, 32'h0000_0000, 4'hF);
		chk("ctrl_rst", r, 32'h0000_0000);
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_0055, 4'hF);
		// pins ask for load and count, software mode must ignore them
		i_ctl.drive(1'b1, 1'b1, 1'b0, 4'h0);
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_00F0, 4'hE);
		wb(1'b0, LUC_OFS_CTRL, 32'h0000_0000, 4'hF);
		chk("ctrl", r, 32'h0000_0055);
		wb(1'b1, LUC_OFS_LOAD, 32'h0000_0001, 4'hF);
		repeat (3) @(posedge clk);
		wb(1'b0, LUC_OFS_STATUS, 32'h0000_0000, 4'hF);
		chk("status", r, 32'h0000_0015);
		chk("state", {s3, s2, s1, s0}, 4'h5);
		wb(1'b0, 8'h0C, 32'h0000_0000, 4'hF);
		chk("unmapped", r, 32'h0000_0000);
		// software count down: enabled from the write edge to the stop write edge, three steps
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_0057, 4'hF);
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_0051, 4'hF);
		wb(1'b0, LUC_OFS_STATUS, 32'h0000_0000, 4'hF);
		chk("sw_down", r, 32'h0000_0012);
		// software clear by loading zero
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_0001, 4'hF);
		wb(1'b1, LUC_OFS_LOAD, 32'h0000_0001, 4'hF);
		repeat (2) @(posedge clk);
		wb(1'b0, LUC_OFS_STATUS, 32'h0000_0000, 4'hF);
		chk("sw_clear", r, 32'h0000_0010);
		chk("sw_state", {s3, s2, s1, s0}, 4'h0);
		i_ctl.drive(1'b0, 1'b0, 1'b0, 4'h0);
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_0000, 4'hF);
	endtask : t_regs

	// mid-run reset: control returns to pin mode, the count survives
	task automatic t_reset();
		step(1'b1, 1'b0, 1'b0, 4'h9, 1, 4'h9);
		wb(1'b1, LUC_OFS_CTRL, 32'h0000_0001, 4'hF);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("kept", {s3, s2, s1, s0}, 4'h9);
		chk("hold_rst", hold, 1'b0);
		wb(1'b0, LUC_OFS_CTRL, 32'h0000_0000, 4'hF);
		chk("ctrl_clr", r, 32'h0000_0000);
		step(1'b0, 1'b1, 1'b0, 4'h0, 2, 4'hB);
	endtask : t_reset

	// ----------------------------------------
	// sequence and verdict
	// ----------------------------------------
	task automatic print_verdict();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	// reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_load();
		t_count();
		t_regs();
		t_reset();
		print_verdict();
	end

	// hang guard
	initial begin
		#20000;
		bad_count++;
		print_verdict();
	end
endmodule : luc_counter_tb
